//--- inc/ssd_pkg.sv
// Package with constants and carrier types for the sensor safety diagnostics block.
package ssd_pkg;
  localparam int CLK_MHZ = 50;
  // Readback timeouts in microseconds, lower bound of each printed window.
  localparam int RB_T1_US = 24;
  localparam int RB_T2_US = 56;
  localparam int RB_T3_US = 112;
  localparam int RB_T1_CYC = RB_T1_US * CLK_MHZ;
  localparam int RB_T2_CYC = RB_T2_US * CLK_MHZ;
  localparam int RB_T3_CYC = RB_T3_US * CLK_MHZ;
  localparam int CORDIC_US = 111;
  localparam int CORDIC_CYC = CORDIC_US * CLK_MHZ;
  localparam int RECOVERY_US = 1000;
  localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  localparam int RETRY_US = 1000;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int ANG_W = 12;
  // Register map.
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_LIVE = 4'h3;
  localparam logic [3:0] ADDR_LIMIT = 4'h4;
  localparam int EV_W = 16;
  // Status bit positions.
  localparam int EV_WDOG = 0;
  localparam int EV_OFFS = 1;
  localparam int EV_CORD = 2;
  localparam int EV_FIELD = 3;
  localparam int EV_SUPPLY = 4;
  localparam int EV_ADC = 5;
  localparam int EV_SIG = 6;
  localparam int EV_RB = 7;
  localparam logic [ANG_W-1:0] LIMIT_RST = 12'h040;

  typedef struct packed {
    logic [4:0] spare;
    logic analog_mode;
    logic [2:0] analog_readback_debounce;
    logic [1:0] fall_readback_timeout;
    logic [1:0] rise_readback_timeout;
    logic failure_band_select;
  } ssd_cfg_t;
  localparam ssd_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic wdog;
    logic offs;
    logic cordic_ovf;
    logic field;
    logic vreg_uv;
    logic rev_pol;
    logic vdd_ov;
    logic vdd_uv;
    logic vdd_broken;
    logic gnd_broken;
    logic short_circ;
    logic adc;
    logic sig;
  } ssd_flt_t;

  typedef enum logic [1:0] {OUT_NORMAL, OUT_BAND_LOW, OUT_BAND_HIGH, OUT_HIZ} ssd_out_t;
endpackage

//--- verilog/ssd_top.sv
// Fault supervisor deciding output safe state and checking output readback.
// Functional notes
// - Watchdog fault latches until reset and releases the output to high impedance.
// - Incomplete offset compensation forces the failure band, recovering automatically.
// - CORDIC overflow forces the failure band until field falls below threshold.
// - Field out of range holds failure band until back in range plus recovery time.
// - Supply, ground, short or polarity faults release output to high impedance, self-recovering.
// - ADC check failure releases output to high impedance, latched until reset.
// - Signature failure releases output to high impedance, latched until reset.
// - Band select chooses lower or upper failure band for band-forcing faults.
// - Digital readback: each edge must see the opposite edge within timeout.
// - After readback failure, wait a fixed time then restore the output and restart the check.
// - Rise timeout code: off, 24-28, 56-60, 112-120 microseconds.
// - Fall timeout code: off, 24-28, 56-60, 112-120 microseconds.
// - Analog readback: output level versus angle beyond limit for debounce releases driver.
// - Debounce code 0..7 selects 0,1,2,4,8,16,32,64 CORDIC cycles; 0 disables.
// - Debounce counting uses the CORDIC cycle, typically 111 microseconds.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
module ssd_top
  import ssd_pkg::*;
#(
  parameter int RECOVERY_CYCLES = RECOVERY_CYC,
  parameter int RETRY_CYCLES = RETRY_CYC,
  parameter int CORDIC_CYCLES = CORDIC_CYC
)(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire ssd_flt_t FAULTS,
  input wire logic FIELD_IN_RANGE,
  input wire logic OUT_READBACK,
  input wire logic [ANG_W-1:0] ANALOG_READBACK,
  input wire logic [ANG_W-1:0] ANGLE,
  output ssd_out_t OUT_STATE,
  output logic OUT_HIGH_IMPEDANCE,
  output logic IRQ
);
  ssd_cfg_t cfg_reg;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] live;
  logic [ANG_W-1:0] limit_reg;
  ssd_flt_t f1_reg;
  ssd_flt_t f2_reg;
  ssd_flt_t f3_reg;
  ssd_flt_t flt;
  logic [2:0] rb_sync_reg;
  logic wdog_lat_reg;
  logic adc_lat_reg;
  logic sig_lat_reg;
  logic field_bad_reg;
  logic [CNT_W-1:0] rec_cnt_reg;
  logic rb_level_reg;
  logic [CNT_W-1:0] edge_cnt_reg;
  logic rb_fail_reg;
  logic [CNT_W-1:0] retry_cnt_reg;
  logic [CNT_W-1:0] cordic_cnt_reg;
  logic cordic_tick;
  logic [6:0] deb_cnt_reg;
  logic [6:0] deb_lim;
  logic [CNT_W-1:0] rise_lim;
  logic [CNT_W-1:0] fall_lim;
  logic [ANG_W-1:0] diff;
  logic any_lat;
  logic any_hiz_rec;
  logic any_band;
  logic rb_edge;
  logic rb_now;

  // Three-stage synchroniser; a change counts once stages two and three agree.
  always_ff @(posedge CORE_CLK)
  begin
    f1_reg <= FAULTS;
    f2_reg <= f1_reg;
    f3_reg <= f2_reg;
  end

  // The readback pin is driven from outside, so it gets the same three stages.
  always_ff @(posedge CORE_CLK)
  begin
    rb_sync_reg <= {rb_sync_reg[1:0], OUT_READBACK};
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      flt <= '0;
    end
    else
    begin
      flt <= (f2_reg == f3_reg) ? f3_reg : flt;
    end
  end

  assign rb_now = (rb_sync_reg[2] == rb_sync_reg[1]) ? rb_sync_reg[2] : rb_level_reg;
  assign rb_edge = rb_now != rb_level_reg;

  // Latched faults only clear with reset, so a flicker cannot hide them.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      wdog_lat_reg <= 1'b0;
      adc_lat_reg <= 1'b0;
      sig_lat_reg <= 1'b0;
    end
    else
    begin
      wdog_lat_reg <= wdog_lat_reg | flt.wdog;
      adc_lat_reg <= adc_lat_reg | flt.adc;
      sig_lat_reg <= sig_lat_reg | flt.sig;
    end
  end

  // Field fault recovery timer restarts on every out-of-range sample.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      field_bad_reg <= 1'b0;
      rec_cnt_reg <= '0;
    end
    else if (flt.field || !FIELD_IN_RANGE)
    begin
      field_bad_reg <= 1'b1;
      rec_cnt_reg <= '0;
    end
    else if (field_bad_reg)
    begin
      if (rec_cnt_reg >= CNT_W'(RECOVERY_CYCLES - 1))
      begin
        field_bad_reg <= 1'b0;
      end
      else
      begin
        rec_cnt_reg <= rec_cnt_reg + 1'b1;
      end
    end
  end

  always_comb
  begin
    case (cfg_reg.rise_readback_timeout)
      2'b01: rise_lim = CNT_W'(RB_T1_CYC);
      2'b10: rise_lim = CNT_W'(RB_T2_CYC);
      2'b11: rise_lim = CNT_W'(RB_T3_CYC);
      default: rise_lim = '0;
    endcase
    case (cfg_reg.fall_readback_timeout)
      2'b01: fall_lim = CNT_W'(RB_T1_CYC);
      2'b10: fall_lim = CNT_W'(RB_T2_CYC);
      2'b11: fall_lim = CNT_W'(RB_T3_CYC);
      default: fall_lim = '0;
    endcase
  end

  // CORDIC-cycle tick for debounce.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      cordic_cnt_reg <= '0;
    end
    else if (cordic_tick)
    begin
      cordic_cnt_reg <= '0;
    end
    else
    begin
      cordic_cnt_reg <= cordic_cnt_reg + 1'b1;
    end
  end
  assign cordic_tick = cordic_cnt_reg == CNT_W'(CORDIC_CYCLES - 1);

  assign deb_lim = 7'(1 << (cfg_reg.analog_readback_debounce - 3'h1));
  assign diff = (ANALOG_READBACK > ANGLE) ? ANALOG_READBACK - ANGLE : ANGLE - ANALOG_READBACK;

  // Readback supervision; while failed the driver is off and the check pauses.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      rb_level_reg <= 1'b0;
      edge_cnt_reg <= '0;
      deb_cnt_reg <= '0;
      rb_fail_reg <= 1'b0;
      retry_cnt_reg <= '0;
    end
    else if (rb_fail_reg)
    begin
      rb_level_reg <= rb_now;
      edge_cnt_reg <= '0;
      deb_cnt_reg <= '0;
      if (retry_cnt_reg >= CNT_W'(RETRY_CYCLES - 1))
      begin
        rb_fail_reg <= 1'b0;
        retry_cnt_reg <= '0;
      end
      else
      begin
        retry_cnt_reg <= retry_cnt_reg + 1'b1;
      end
    end
    else if (!cfg_reg.analog_mode)
    begin
      rb_level_reg <= rb_now;
      deb_cnt_reg <= '0;
      if (rb_edge)
      begin
        edge_cnt_reg <= '0;
      end
      else
      begin
        edge_cnt_reg <= edge_cnt_reg + 1'b1;
      end
      // Low level waits for rise; high level waits for fall.
      if (!rb_edge && !rb_level_reg && rise_lim != '0 && edge_cnt_reg >= rise_lim)
      begin
        rb_fail_reg <= 1'b1;
      end
      if (!rb_edge && rb_level_reg && fall_lim != '0 && edge_cnt_reg >= fall_lim)
      begin
        rb_fail_reg <= 1'b1;
      end
    end
    else if (cfg_reg.analog_readback_debounce != 3'h0)
    begin
      edge_cnt_reg <= '0;
      if (diff <= limit_reg)
      begin
        deb_cnt_reg <= '0;
      end
      else if (cordic_tick)
      begin
        if (deb_cnt_reg + 7'h01 >= deb_lim)
          rb_fail_reg <= 1'b1;
        else
          deb_cnt_reg <= deb_cnt_reg + 7'h01;
      end
    end
  end

  assign any_lat = wdog_lat_reg | adc_lat_reg | sig_lat_reg;
  assign any_hiz_rec = flt.vreg_uv | flt.rev_pol | flt.vdd_ov | flt.vdd_uv | flt.vdd_broken
    | flt.gnd_broken | flt.short_circ | rb_fail_reg;
  assign any_band = flt.offs | flt.cordic_ovf | field_bad_reg;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      OUT_STATE <= OUT_HIZ;
    end
    else if (any_lat)
    begin
      OUT_STATE <= OUT_HIZ;
    end
    else if (any_hiz_rec)
    begin
      OUT_STATE <= OUT_HIZ;
    end
    else if (any_band)
    begin
      OUT_STATE <= cfg_reg.failure_band_select ? OUT_BAND_HIGH : OUT_BAND_LOW;
    end
    else
    begin
      OUT_STATE <= OUT_NORMAL;
    end
  end

  // Released while in reset, so the line never shows a stale level at power up.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      OUT_HIGH_IMPEDANCE <= 1'b1;
    end
    else
    begin
      OUT_HIGH_IMPEDANCE <= any_lat | any_hiz_rec;
    end
  end

  always_comb
  begin
    live = '0;
    live[EV_WDOG] = wdog_lat_reg;
    live[EV_OFFS] = flt.offs;
    live[EV_CORD] = flt.cordic_ovf;
    live[EV_FIELD] = field_bad_reg;
    live[EV_SUPPLY] = any_hiz_rec & ~rb_fail_reg;
    live[EV_ADC] = adc_lat_reg;
    live[EV_SIG] = sig_lat_reg;
    live[EV_RB] = rb_fail_reg;
  end

  // Configuration registers.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      cfg_reg <= CFG_RST;
      mask_reg <= '0;
      limit_reg <= LIMIT_RST;
    end
    else if (WR)
    begin
      if (ADDR == ADDR_CFG)
      begin
        cfg_reg <= ssd_cfg_t'(WDATA[$bits(ssd_cfg_t)-1:0]);
      end
      if (ADDR == ADDR_MASK)
      begin
        mask_reg <= WDATA;
      end
      if (ADDR == ADDR_LIMIT)
      begin
        limit_reg <= WDATA[ANG_W-1:0];
      end
    end
  end

  // Sticky status: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      stat_reg <= '0;
    end
    else if (WR && ADDR == ADDR_STAT)
    begin
      stat_reg <= (stat_reg & ~WDATA) | live;
    end
    else
    begin
      stat_reg <= stat_reg | live;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(stat_reg & mask_reg);
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      RDATA <= '0;
    end
    else if (RD)
    begin
      case (ADDR)
        ADDR_CFG: RDATA <= 16'(cfg_reg);
        ADDR_STAT: RDATA <= stat_reg;
        ADDR_MASK: RDATA <= mask_reg;
        ADDR_LIVE: RDATA <= live;
        ADDR_LIMIT: RDATA <= 16'(limit_reg);
        default: RDATA <= '0;
      endcase
    end
    else
    begin
      RDATA <= '0;
    end
  end
endmodule // ssd_top

//--- dv/ssd_line_model.sv
// Output line as seen by the receiving control unit, with its pull-up.
`timescale 1ns/1ps
module ssd_line_model
(
  input wire logic clk,
  input wire logic output_high_impedance,
  input wire logic stuck_en,
  input wire logic stuck_val,
  output logic line
);
  logic [6:0] cnt = 7'h00;
  logic pwm = 1'b0;
  always_ff @(posedge clk)
  begin
    cnt <= (cnt == 7'h63) ? 7'h00 : cnt + 7'h01;
    pwm <= (cnt == 7'h63) ? ~pwm : pwm;
  end
  // A short on the line beats both the driver and the pull-up.
  assign line = stuck_en ? stuck_val : (output_high_impedance ? 1'b1 : pwm);
endmodule // ssd_line_model

//--- dv/ssd_chk_sva.sv
// Port checker for the safety supervisor.
`timescale 1ns/1ps
module ssd_chk
  import ssd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire ssd_flt_t FAULTS,
  input wire logic OUT_READBACK,
  input wire ssd_out_t OUT_STATE,
  input wire logic OUT_HIGH_IMPEDANCE
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  logic [15:0] cfg_q;
  int low_cnt;
  int rise_to;
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      cfg_q <= 16'h0000;
    else if (WR && ADDR == ADDR_CFG)
      cfg_q <= WDATA;
  end
  // Saturating, so a line stuck low cannot wrap into a second match.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B || OUT_READBACK || (WR && ADDR == ADDR_CFG))
      low_cnt <= 0;
    else if (low_cnt < 9000)
      low_cnt <= low_cnt + 1;
  end
  assign rise_to = (cfg_q[2:1] == 2'h1) ? RB_T1_CYC : (cfg_q[2:1] == 2'h2) ? RB_T2_CYC :
    (cfg_q[2:1] == 2'h3) ? RB_T3_CYC : 0;
  sequence s_hiz8;
    (OUT_STATE == OUT_HIZ) [*8];
  endsequence
  sequence s_field_off;
    (OUT_STATE != OUT_NORMAL) && $fell(FAULTS.field);
  endsequence
  property p_wdog;
    FAULTS.wdog |-> ##[1:6] s_hiz8;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog hold lost");
  property p_adc;
    FAULTS.adc |-> ##[1:6] s_hiz8;
  endproperty
  a_adc: assert property (p_adc) else $error("adc hold lost");
  property p_sig;
    FAULTS.sig |-> ##[1:6] s_hiz8;
  endproperty
  a_sig: assert property (p_sig) else $error("signature hold lost");
  property p_supply;
    |FAULTS[8:2] |-> ##[1:6] OUT_STATE == OUT_HIZ;
  endproperty
  a_supply: assert property (p_supply) else $error("supply fault not released");
  property p_band;
    (FAULTS.offs || FAULTS.cordic_ovf) |-> ##[1:6] OUT_STATE != OUT_NORMAL;
  endproperty
  a_band: assert property (p_band) else $error("band not forced");
  property p_band_sel;
    (OUT_STATE inside {OUT_BAND_LOW, OUT_BAND_HIGH}) && $stable(cfg_q[0])
      |-> OUT_STATE == (cfg_q[0] ? OUT_BAND_HIGH : OUT_BAND_LOW);
  endproperty
  a_band_sel: assert property (p_band_sel) else $error("wrong band");
  property p_field;
    s_field_off |-> (OUT_STATE != OUT_NORMAL) [*8];
  endproperty
  a_field: assert property (p_field) else $error("field left band early");
  property p_rise;
    (!cfg_q[8] && rise_to != 0 && low_cnt == rise_to + 8) |-> OUT_HIGH_IMPEDANCE;
  endproperty
  a_rise: assert property (p_rise) else $error("rise timeout missed");
endmodule // ssd_chk

bind ssd_top ssd_chk chk_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .FAULTS(FAULTS), .OUT_READBACK(OUT_READBACK),
  .OUT_STATE(OUT_STATE), .OUT_HIGH_IMPEDANCE(OUT_HIGH_IMPEDANCE));

//--- dv/testbench.sv
// Self-checking bench for the safety supervisor.
`timescale 1ns/1ps
module testbench
  import ssd_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, fir = 1'b1;
  logic st_en = 1'b0, st_v = 1'b0, out_hiz, irq, line;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [11:0] ang_rb = 12'h100, angle = 12'h100;
  ssd_flt_t faults = '0;
  ssd_out_t out_st;
  int err_count = 0, tests_run = 0;
  always #10 clk = ~clk;
  ssd_top #(.RECOVERY_CYCLES(20), .RETRY_CYCLES(20), .CORDIC_CYCLES(4)) dut_u (
    .CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .FAULTS(faults), .FIELD_IN_RANGE(fir), .OUT_READBACK(line),
    .ANALOG_READBACK(ang_rb), .ANGLE(angle), .OUT_STATE(out_st),
    .OUT_HIGH_IMPEDANCE(out_hiz), .IRQ(irq));
  ssd_line_model line_u (.clk(clk), .output_high_impedance(out_hiz), .stuck_en(st_en), .stuck_val(st_v),
    .line(line));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input ssd_out_t e);
    @(negedge clk);
    chk({13'h0, out_hiz, out_st}, {13'h0, e == OUT_HIZ, e});
    @(posedge clk);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk({15'h0, irq}, {15'h0, e});
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic flt(input int b, input logic v, input int n);
    faults[b] <= v;
    tick(n);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    tick(6);
    rst_b <= 1'b1;
    tick(4);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    tick(100000);
    err_count++;
    close_out();
  end
  initial
  begin
    int to;
    int w;
    do_reset();
    rd_reg(ADDR_LIMIT, {4'h0, LIMIT_RST});
    wr_reg(4'hf, 16'hffff);
    rd_reg(4'hf, 16'h0000);
    rd_reg(ADDR_CFG, 16'h0000);
    wr_reg(ADDR_MASK, 16'h0010);
    flt(8, 1'b1, 8);
    chk_irq(1'b1);
    flt(8, 1'b0, 8);
    chk_irq(1'b1);
    rd_reg(ADDR_STAT, 16'h0010);
    wr_reg(ADDR_STAT, 16'h0010);
    chk_irq(1'b0);
    wr_reg(ADDR_MASK, 16'h0000);
    $display("done regs irq");
    for (int b = 2; b <= 8; b++)
    begin
      flt(b, 1'b1, 8);
      chk_out(OUT_HIZ);
      flt(b, 1'b0, 8);
      chk_out(OUT_NORMAL);
    end
    for (int s = 0; s < 2; s++)
    begin
      wr_reg(ADDR_CFG, 16'(s));
      for (int b = 10; b <= 11; b++)
      begin
        flt(b, 1'b1, 8);
        chk_out(s ? OUT_BAND_HIGH : OUT_BAND_LOW);
        flt(b, 1'b0, 8);
        chk_out(OUT_NORMAL);
      end
    end
    fir <= 1'b0;
    flt(9, 1'b1, 8);
    chk_out(OUT_BAND_HIGH);
    rd_reg(ADDR_LIVE, 16'h0008);
    flt(9, 1'b0, 30);
    chk_out(OUT_BAND_HIGH);
    fir <= 1'b1;
    tick(10);
    chk_out(OUT_BAND_HIGH);
    tick(30);
    chk_out(OUT_NORMAL);
    $display("done recoverable");
    for (int i = 0; i < 3; i++)
    begin
      w = (i == 0) ? 12 : i - 1;
      flt(w, 1'b1, 8);
      chk_out(OUT_HIZ);
      flt(w, 1'b0, 8);
      flt(8, 1'b1, 8);
      flt(8, 1'b0, 12);
      chk_out(OUT_HIZ);
      do_reset();
      chk_out(OUT_NORMAL);
    end
    $display("done latched");
    for (int i = 0; i < 6; i++)
    begin
      w = i % 3 + 1;
      to = (w == 1) ? RB_T1_CYC : (w == 2) ? RB_T2_CYC : RB_T3_CYC;
      wr_reg(ADDR_CFG, 16'(w << ((i < 3) ? 1 : 3)));
      tick(300);
      chk_out(OUT_NORMAL);
      st_v <= (i >= 3);
      st_en <= 1'b1;
      tick(to - 140);
      chk_out(OUT_NORMAL);
      tick(150);
      chk_out(OUT_HIZ);
      st_en <= 1'b0;
      tick(60);
      chk_out(OUT_NORMAL);
    end
    wr_reg(ADDR_CFG, 16'h0000);
    st_v <= 1'b0;
    st_en <= 1'b1;
    tick(RB_T1_CYC + 100);
    chk_out(OUT_NORMAL);
    st_en <= 1'b0;
    $display("done digital");
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(ADDR_CFG, 16'h0100 | 16'(c << 5));
      ang_rb <= 12'h141;
      w = (c == 0) ? 256 : (1 << (c - 1)) * 4;
      tick(w + 12);
      chk_out(c ? OUT_HIZ : OUT_NORMAL);
      ang_rb <= 12'h140;
      tick(60);
      chk_out(OUT_NORMAL);
    end
    $display("done analog");
    close_out();
  end
endmodule // testbench
